// ===== pfm_pad_cell.sv
// pfm_pad_cell: one pad, option decode, driver enable and input gating
`timescale 1ns/1ps
`default_nettype none
module pfm_pad_cell (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [1:0] alt_sel,
    input wire logic input_buffer_enable,
    input wire logic analog_pad_control,
    input wire logic slew,
    input wire logic [pfm_pkg::PFM_OPTIONS-1:0] opt_out,
    input wire logic [pfm_pkg::PFM_OPTIONS-1:0] opt_drv,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe_n,
    output logic func_in,
    output logic ana_en,
    output logic medium_drv
);
    // ==========================================
    // output path: selected option drives, analog use keeps driver off
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe_n <= 1'b1;
        end else begin
            pad_out <= opt_out[alt_sel];
            pad_oe_n <= ~opt_drv[alt_sel] | analog_pad_control;
        end
    end

    // ==========================================
    // input path: only an enabled buffer reaches the peripheral
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            func_in <= pfm_pkg::INACTIVE_LEVEL;
        end else if (input_buffer_enable && !analog_pad_control) begin
            func_in <= pad_in;
        end else begin
            func_in <= pfm_pkg::INACTIVE_LEVEL;
        end
    end

    // ==========================================
    // analog switch and driver strength
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ana_en <= 1'b0;
            medium_drv <= 1'b0;
        end else begin
            ana_en <= analog_pad_control;
            medium_drv <= slew;
        end
    end
endmodule
`default_nettype wire

// ===== pfm_pins.sv
// pfm_pins: outside pin model that resolves each pad wire
`timescale 1ns/1ps
`default_nettype none
module pfm_pins #(
    parameter int N = 16
) (
    input wire logic [N-1:0] pad_out,
    input wire logic [N-1:0] pad_oe_n,
    input wire logic [N-1:0] ext_level,
    output logic [N-1:0] pad_in
);
    // driven pads show the device level, else the outside level
    always_comb begin
        for (int p = 0; p < N; p++) begin
            pad_in[p] = pad_oe_n[p] ? ext_level[p] : pad_out[p];
        end
    end
endmodule
`default_nettype wire

// ===== pfm_pkg.sv
// pfm_pkg: shared constants and types of the pad function multiplexer
package pfm_pkg;
    // ==========================================
    // sizes
    localparam int PFM_PADS = 16;
    localparam int PFM_OPTIONS = 4;
    localparam int PFM_SENSOR_PADS = 16;
    localparam int PFM_ROUTE_N = 4;
    localparam int PFM_ROUTE_BASE = 4;
    localparam int PFM_CHAN_W = 7;
    localparam int PFM_EXT_SEL_W = 3;
    // ==========================================
    // pad configuration register layout
    localparam int CFG_W = 5;
    localparam int CFG_ALT_LSB = 0;
    localparam int CFG_ALT_W = 2;
    localparam int CFG_IBE = 2;
    localparam int CFG_APC = 3;
    localparam int CFG_SLEW = 4;
    localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
    // ==========================================
    // alternate function select codes
    localparam logic [1:0] ALT_OPT0 = 2'h0;
    localparam logic [1:0] ALT_OPT1 = 2'h1;
    localparam logic [1:0] ALT_OPT2 = 2'h2;
    localparam logic [1:0] ALT_OPT3 = 2'h3;
    // ==========================================
    // test port pads after reset
    localparam int JTAG_TCK_PAD = 0;
    localparam int JTAG_TDI_PAD = 1;
    localparam int JTAG_TDO_PAD = 2;
    localparam int JTAG_TMS_PAD = 3;
    localparam int JTAG_PADS = 4;
    // level shown to a peripheral input with no enabled pad
    localparam logic INACTIVE_LEVEL = 1'b0;
    // ==========================================
    // converter channel windows
    localparam logic [PFM_CHAN_W-1:0] SENSOR_CH_BASE = 7'h20;
    localparam logic [PFM_CHAN_W-1:0] SENSOR_CH_END = 7'h30;
    localparam logic [PFM_CHAN_W-1:0] EXT_CH_BASE = 7'h40;
    localparam logic [PFM_CHAN_W-1:0] EXT_CH_END = 7'h48;
    // ==========================================
    // quad serial port pad slots
    localparam int QP_CS0 = 0;
    localparam int QP_CS1 = 1;
    localparam int QP_CS2 = 2;
    localparam int QP_D0 = 3;
    localparam int QP_D1 = 4;
    localparam int QP_SCK = 5;
    localparam int QP_PADS = 6;
    localparam int SPI_CS_N = 3;
    // boot choice, gray along flash -> can -> lin
    typedef enum logic [1:0] {
        PFM_BOOT_FLASH = 2'h0,
        PFM_BOOT_CAN = 2'h1,
        PFM_BOOT_LIN = 2'h3
    } pfm_boot_t;
endpackage

// ===== pfm_sva.sv
// pfm_sva: port-level timing checks of the pad function multiplexer
`timescale 1ns/1ps
`default_nettype none
module pfm_sva #(
    parameter int NUM_PADS = 16,
    parameter int ROUTE_N = 4,
    parameter int ROUTE_BASE = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [NUM_PADS-1:0] pad_func_in,
    input wire logic [$clog2(ROUTE_N)-1:0] input_routing_select,
    input wire logic routed_in,
    input wire logic [6:0] converter_channel,
    input wire logic [15:0] analog_sensor_inputs,
    input wire logic [2:0] ext_analog_mux_select,
    input wire logic ext_analog_mux_active,
    input wire logic force_alternate_boot,
    input wire pfm_pkg::pfm_boot_t boot_mode,
    input wire logic boot_valid,
    input wire logic [3:0] jtag_owned,
    input wire logic jtag_tck,
    input wire logic spi_master,
    input wire logic [2:0] spi_cs,
    input wire logic [2:0] spi_cs_out,
    input wire logic [2:0] spi_cs_drv,
    input wire logic qspi_master,
    input wire logic serial_flash_mode,
    input wire logic [3:0] qspi_io_oe,
    input wire logic [5:0] qspi_opt_drv
);
    // ==========================================
    // single clock domain, reset silences every check
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_route_follow: assert property (routed_in == $past(pad_func_in[ROUTE_BASE + input_routing_select]))
        else $error("routed input off its pad");
    a_sensor_map: assert property (analog_sensor_inputs != 16'h0000 |-> $past(converter_channel) inside {[32:47]}
        && analog_sensor_inputs == (16'h0001 << ($past(converter_channel) - 7'h20)))
        else $error("sensor channel map wrong");
    a_ext_select: assert property (converter_channel inside {[64:71]} |=>
        ext_analog_mux_active && ext_analog_mux_select == $past(converter_channel[2:0]))
        else $error("external mux select wrong");
    a_ext_idle: assert property (!(converter_channel inside {[64:71]}) |=>
        !ext_analog_mux_active && $stable(ext_analog_mux_select))
        else $error("external mux not idle");
    a_boot_pick: assert property ($rose(boot_valid) |->
        (boot_mode == pfm_pkg::PFM_BOOT_FLASH) == !$past(force_alternate_boot))
        else $error("boot choice wrong");
    a_boot_hold: assert property (boot_valid |=> boot_valid && $stable(boot_mode))
        else $error("boot choice moved");
    a_jtag_reset: assert property ($fell(rst) |-> jtag_owned == 4'hF)
        else $error("test pads not owned after reset");
    a_jtag_clock: assert property (jtag_owned[0] |-> jtag_tck == pad_func_in[0])
        else $error("test clock not from pad 0");
    a_spi_slave: assert property (!spi_master |=> spi_cs_drv == 3'h0 && spi_cs_out == 3'h0)
        else $error("chip select driven as slave");
    a_spi_master: assert property (spi_master |=> spi_cs_out == $past(spi_cs))
        else $error("chip select value wrong");
    a_flash_dirs: assert property (serial_flash_mode |=> qspi_opt_drv[5] && qspi_opt_drv[0]
        && qspi_opt_drv[3] == $past(qspi_io_oe[0]) && qspi_opt_drv[1] == $past(qspi_io_oe[2]))
        else $error("flash mode drive wrong");
    a_spi_slave_q: assert property (!serial_flash_mode && !qspi_master |=>
        qspi_opt_drv[2:0] == 3'h0 && !qspi_opt_drv[5])
        else $error("quad port drives as slave");
endmodule
`default_nettype wire

// ===== pfm_top.sv
// pfm_top: pad function multiplexer for the general purpose pads
// How it works
// - select code 00..11 routes output option 0..3 to the pad
// - a pad reaches an input function only while its buffer enable is 1
// - special functions are separate; digital use on them is blocked
// - analog control bit connects the converter path; others follow their module
// - an input routing select picks which pad feeds the shared input
// - after reset pads 0..3 carry test clock, data in, data out, mode
// - slew control off gives slow driver, on gives medium driver
// - three external mux selects pick one of 8 channels 64..71
// - sixteen sensor pads 0..15 map to converter channels 32..47
// - forced alternate boot downloads over CAN or LIN, else boots flash
// - the alternate boot select input chooses CAN or LIN
// - serial chip selects 0..2 drive only while that port is master
// - quad port cs1/cs2 are chip selects in SPI, data 2/3 in flash mode
// - quad port data in/out are SPI lines, or data 0/1 in flash mode
// - quad port clock is output in master and flash, input in slave
// - quad port pad options follow SPI or serial flash mode
`timescale 1ns/1ps
`default_nettype none
module pfm_top #(
    parameter int NUM_PADS = pfm_pkg::PFM_PADS,
    parameter int ROUTE_N = pfm_pkg::PFM_ROUTE_N,
    parameter int ROUTE_BASE = pfm_pkg::PFM_ROUTE_BASE
) (
    input wire logic clk_sys,
    input wire logic rst,
    // pad configuration register write and readback
    input wire logic cfg_wr,
    input wire logic [$clog2(NUM_PADS)-1:0] cfg_pad,
    input wire logic [pfm_pkg::CFG_W-1:0] cfg_data,
    output logic [pfm_pkg::CFG_W-1:0] cfg_rdata,
    output logic cfg_rd_jtag_owned,
    // input routing select register
    input wire logic route_wr,
    input wire logic [$clog2(ROUTE_N)-1:0] route_data,
    output logic [$clog2(ROUTE_N)-1:0] input_routing_select,
    output logic routed_in,
    // per pad output options from peripherals, four per pad
    input wire logic [NUM_PADS*pfm_pkg::PFM_OPTIONS-1:0] opt_out,
    input wire logic [NUM_PADS*pfm_pkg::PFM_OPTIONS-1:0] opt_drv,
    // pad pins
    input wire logic [NUM_PADS-1:0] pad_in,
    output logic [NUM_PADS-1:0] pad_out,
    output logic [NUM_PADS-1:0] pad_oe_n,
    output logic [NUM_PADS-1:0] pad_func_in,
    output logic [NUM_PADS-1:0] pad_ana_en,
    output logic [NUM_PADS-1:0] pad_medium_drv,
    // test port
    input wire logic jtag_tdo,
    output logic jtag_tck,
    output logic jtag_tdi,
    output logic jtag_tms,
    output logic [pfm_pkg::JTAG_PADS-1:0] jtag_owned,
    // converter channel routing
    input wire logic [pfm_pkg::PFM_CHAN_W-1:0] converter_channel,
    output logic [pfm_pkg::PFM_SENSOR_PADS-1:0] analog_sensor_inputs,
    output logic [pfm_pkg::PFM_EXT_SEL_W-1:0] ext_analog_mux_select,
    output logic ext_analog_mux_active,
    // boot selection
    input wire logic force_alternate_boot,
    input wire logic alternate_boot_select,
    output pfm_pkg::pfm_boot_t boot_mode,
    output logic boot_valid,
    // serial port chip selects
    input wire logic spi_master,
    input wire logic [pfm_pkg::SPI_CS_N-1:0] spi_cs,
    output logic [pfm_pkg::SPI_CS_N-1:0] spi_cs_out,
    output logic [pfm_pkg::SPI_CS_N-1:0] spi_cs_drv,
    // quad serial port core side
    input wire logic qspi_master,
    input wire logic serial_flash_mode,
    input wire logic [pfm_pkg::SPI_CS_N-1:0] qspi_cs,
    input wire logic qspi_sck_out,
    input wire logic qspi_sout,
    input wire logic [3:0] qspi_io_out,
    input wire logic [3:0] qspi_io_oe,
    output logic qspi_sck_in,
    output logic qspi_sin,
    output logic [3:0] qspi_io_in,
    // quad serial port pad side, to be wired into option inputs
    input wire logic [pfm_pkg::QP_PADS-1:0] qspi_pad_level,
    output logic [pfm_pkg::QP_PADS-1:0] qspi_opt_out,
    output logic [pfm_pkg::QP_PADS-1:0] qspi_opt_drv
);
    localparam int OPT = pfm_pkg::PFM_OPTIONS;
    localparam int PAD_W = $clog2(NUM_PADS);

    // ==========================================
    // elaboration checks
    if (NUM_PADS < pfm_pkg::PFM_SENSOR_PADS) begin : g_chk_pads
        $error("pfm_top: NUM_PADS must cover the sensor pads");
    end
    if (ROUTE_N < 2 || ROUTE_BASE + ROUTE_N > NUM_PADS) begin : g_chk_route
        $error("pfm_top: routing candidates outside the pad range");
    end

    // ==========================================
    // pad configuration registers
    logic [pfm_pkg::CFG_W-1:0] cfg [NUM_PADS];
    logic [pfm_pkg::JTAG_PADS-1:0] jtag_own;

    // software writes one pad at a time; unknown pad numbers are dropped
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int i = 0; i < NUM_PADS; i++) begin
                cfg[i] <= pfm_pkg::CFG_RESET;
            end
        end else if (cfg_wr && int'(cfg_pad) < NUM_PADS) begin
            cfg[cfg_pad] <= cfg_data;
        end
    end

    // test port keeps pads 0..3 until each one is rewritten
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            jtag_own <= '1;
        end else if (cfg_wr && int'(cfg_pad) < pfm_pkg::JTAG_PADS) begin
            jtag_own[cfg_pad[1:0]] <= 1'b0;
        end
    end
    assign jtag_owned = jtag_own;

    // readback of the addressed pad, one cycle late
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg_rdata <= pfm_pkg::CFG_RESET;
            cfg_rd_jtag_owned <= 1'b0;
        end else begin
            cfg_rdata <= cfg[cfg_pad];
            cfg_rd_jtag_owned <= (int'(cfg_pad) < pfm_pkg::JTAG_PADS) ?
                jtag_own[cfg_pad[1:0]] : 1'b0;
        end
    end

    // ==========================================
    // pad cells, with the test port overriding the first four pads
    for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
        logic [1:0] eff_alt;
        logic eff_ibe;
        logic [OPT-1:0] eff_out;
        logic [OPT-1:0] eff_drv;
        logic own;

        assign own = (p < pfm_pkg::JTAG_PADS) ? jtag_own[p % pfm_pkg::JTAG_PADS] : 1'b0;

        // owned pads: option 0 only, data out drives, the others listen
        always_comb begin
            eff_alt = cfg[p][pfm_pkg::CFG_ALT_LSB +: pfm_pkg::CFG_ALT_W];
            eff_ibe = cfg[p][pfm_pkg::CFG_IBE];
            eff_out = opt_out[p*OPT +: OPT];
            eff_drv = opt_drv[p*OPT +: OPT];
            if (own) begin
                eff_alt = pfm_pkg::ALT_OPT0;
                eff_out = {{(OPT-1){1'b0}}, jtag_tdo};
                eff_drv = '0;
                eff_drv[0] = (p == pfm_pkg::JTAG_TDO_PAD);
                eff_ibe = (p != pfm_pkg::JTAG_TDO_PAD);
            end
        end

        pfm_pad_cell u_cell (
            .clk_sys(clk_sys),
            .rst(rst),
            .alt_sel(eff_alt),
            .input_buffer_enable(eff_ibe),
            .analog_pad_control(cfg[p][pfm_pkg::CFG_APC] & ~own),
            .slew(cfg[p][pfm_pkg::CFG_SLEW]),
            .opt_out(eff_out),
            .opt_drv(eff_drv),
            .pad_in(pad_in[p]),
            .pad_out(pad_out[p]),
            .pad_oe_n(pad_oe_n[p]),
            .func_in(pad_func_in[p]),
            .ana_en(pad_ana_en[p]),
            .medium_drv(pad_medium_drv[p])
        );
    end

    // test port inputs fall to the inactive level once released
    always_comb begin
        jtag_tck = pfm_pkg::INACTIVE_LEVEL;
        jtag_tdi = pfm_pkg::INACTIVE_LEVEL;
        jtag_tms = pfm_pkg::INACTIVE_LEVEL;
        if (jtag_own[pfm_pkg::JTAG_TCK_PAD]) begin
            jtag_tck = pad_func_in[pfm_pkg::JTAG_TCK_PAD];
        end
        if (jtag_own[pfm_pkg::JTAG_TDI_PAD]) begin
            jtag_tdi = pad_func_in[pfm_pkg::JTAG_TDI_PAD];
        end
        if (jtag_own[pfm_pkg::JTAG_TMS_PAD]) begin
            jtag_tms = pad_func_in[pfm_pkg::JTAG_TMS_PAD];
        end
    end

    // ==========================================
    // input routing select register and shared input
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            input_routing_select <= '0;
        end else if (route_wr) begin
            input_routing_select <= route_data;
        end
    end

    // gated pad levels already show the inactive level when disabled
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            routed_in <= pfm_pkg::INACTIVE_LEVEL;
        end else if (int'(input_routing_select) < ROUTE_N) begin
            routed_in <= pad_func_in[ROUTE_BASE + int'(input_routing_select)];
        end else begin
            routed_in <= pfm_pkg::INACTIVE_LEVEL;
        end
    end

    // ==========================================
    // converter channel decode
    logic [pfm_pkg::PFM_CHAN_W-1:0] sens_off;
    logic [pfm_pkg::PFM_CHAN_W-1:0] ext_off;
    logic in_sens;
    logic in_ext;

    assign sens_off = converter_channel - pfm_pkg::SENSOR_CH_BASE;
    assign ext_off = converter_channel - pfm_pkg::EXT_CH_BASE;
    assign in_sens = converter_channel >= pfm_pkg::SENSOR_CH_BASE &&
        converter_channel < pfm_pkg::SENSOR_CH_END;
    assign in_ext = converter_channel >= pfm_pkg::EXT_CH_BASE &&
        converter_channel < pfm_pkg::EXT_CH_END;

    // a sensor pad joins the converter only with its analog bit set
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analog_sensor_inputs <= '0;
        end else begin
            for (int k = 0; k < pfm_pkg::PFM_SENSOR_PADS; k++) begin
                analog_sensor_inputs[k] <= in_sens && int'(sens_off) == k &&
                    cfg[k][pfm_pkg::CFG_APC];
            end
        end
    end

    // external mux selects hold their last value when idle, which avoids
    // needless switching of the outside multiplexer
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_analog_mux_select <= '0;
            ext_analog_mux_active <= 1'b0;
        end else begin
            ext_analog_mux_active <= in_ext;
            if (in_ext) begin
                ext_analog_mux_select <= ext_off[pfm_pkg::PFM_EXT_SEL_W-1:0];
            end
        end
    end

    // ==========================================
    // boot straps, caught once at the first edge after reset release
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            boot_mode <= pfm_pkg::PFM_BOOT_FLASH;
            boot_valid <= 1'b0;
        end else if (!boot_valid) begin
            boot_valid <= 1'b1;
            if (!force_alternate_boot) begin
                boot_mode <= pfm_pkg::PFM_BOOT_FLASH;
            end else if (alternate_boot_select) begin
                boot_mode <= pfm_pkg::PFM_BOOT_LIN;
            end else begin
                boot_mode <= pfm_pkg::PFM_BOOT_CAN;
            end
        end
    end

    // ==========================================
    // serial port chip selects, silent in slave mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_cs_out <= '0;
            spi_cs_drv <= '0;
        end else begin
            spi_cs_out <= spi_master ? spi_cs : '0;
            spi_cs_drv <= {pfm_pkg::SPI_CS_N{spi_master}};
        end
    end

    // ==========================================
    // quad serial port pad functions by mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            qspi_opt_out <= '0;
            qspi_opt_drv <= '0;
        end else if (serial_flash_mode) begin
            qspi_opt_out[pfm_pkg::QP_CS0] <= qspi_cs[0];
            qspi_opt_drv[pfm_pkg::QP_CS0] <= 1'b1;
            qspi_opt_out[pfm_pkg::QP_D0] <= qspi_io_out[0];
            qspi_opt_drv[pfm_pkg::QP_D0] <= qspi_io_oe[0];
            qspi_opt_out[pfm_pkg::QP_D1] <= qspi_io_out[1];
            qspi_opt_drv[pfm_pkg::QP_D1] <= qspi_io_oe[1];
            qspi_opt_out[pfm_pkg::QP_CS1] <= qspi_io_out[2];
            qspi_opt_drv[pfm_pkg::QP_CS1] <= qspi_io_oe[2];
            qspi_opt_out[pfm_pkg::QP_CS2] <= qspi_io_out[3];
            qspi_opt_drv[pfm_pkg::QP_CS2] <= qspi_io_oe[3];
            qspi_opt_out[pfm_pkg::QP_SCK] <= qspi_sck_out;
            qspi_opt_drv[pfm_pkg::QP_SCK] <= 1'b1;
        end else begin
            // spi: chip selects and clock only as master, data out always
            qspi_opt_out[pfm_pkg::QP_CS0] <= qspi_cs[0];
            qspi_opt_drv[pfm_pkg::QP_CS0] <= qspi_master;
            qspi_opt_out[pfm_pkg::QP_CS1] <= qspi_cs[1];
            qspi_opt_drv[pfm_pkg::QP_CS1] <= qspi_master;
            qspi_opt_out[pfm_pkg::QP_CS2] <= qspi_cs[2];
            qspi_opt_drv[pfm_pkg::QP_CS2] <= qspi_master;
            qspi_opt_out[pfm_pkg::QP_D0] <= 1'b0;
            qspi_opt_drv[pfm_pkg::QP_D0] <= 1'b0;
            qspi_opt_out[pfm_pkg::QP_D1] <= qspi_sout;
            qspi_opt_drv[pfm_pkg::QP_D1] <= 1'b1;
            qspi_opt_out[pfm_pkg::QP_SCK] <= qspi_sck_out;
            qspi_opt_drv[pfm_pkg::QP_SCK] <= qspi_master;
        end
    end

    // core inputs from pad levels; unused lines rest at the inactive level
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            qspi_sin <= pfm_pkg::INACTIVE_LEVEL;
            qspi_sck_in <= pfm_pkg::INACTIVE_LEVEL;
            qspi_io_in <= '0;
        end else begin
            qspi_sin <= serial_flash_mode ? pfm_pkg::INACTIVE_LEVEL :
                qspi_pad_level[pfm_pkg::QP_D0];
            qspi_sck_in <= (serial_flash_mode || qspi_master) ? pfm_pkg::INACTIVE_LEVEL :
                qspi_pad_level[pfm_pkg::QP_SCK];
            if (serial_flash_mode) begin
                qspi_io_in <= {qspi_pad_level[pfm_pkg::QP_CS2], qspi_pad_level[pfm_pkg::QP_CS1],
                    qspi_pad_level[pfm_pkg::QP_D1], qspi_pad_level[pfm_pkg::QP_D0]};
            end else begin
                qspi_io_in <= '0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb_top.sv
// tb_top: self-checking bench of the pad function multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, wr_en = 1'b0, rt_wr = 1'b0, tdo = 1'b1, fab = 1'b0, alt_boot = 1'b0;
    logic spi_m = 1'b0, q_m = 1'b0, flash = 1'b0, mact, routed, tck, bval, q_sin, q_sck;
    logic [3:0] pad_sel = 4'h0, io_oe = 4'h0, owned, q_io;
    logic [4:0] wdata = 5'h00, rdata;
    logic [1:0] rt_data = 2'h0, rt_sel;
    logic [63:0] o_out = 64'h0, o_drv = 64'h0;
    logic [15:0] ext = 16'h0000, p_in, p_out, p_oe_n, f_in, a_en, med, sens;
    logic [6:0] chan = 7'h00;
    logic [2:0] cs = 3'h5, cs_out, cs_drv, msel;
    logic [5:0] qlev = 6'h00, qdrv, qout;
    pfm_pkg::pfm_boot_t bmode;
    int err_total = 0, comparisons = 0, cyc = 0;
    // ==========================================
    // clock, device and pin model
    always #12.5 clk_sys = ~clk_sys;
    pfm_top u_pfm_top (.clk_sys(clk_sys), .rst(rst), .cfg_wr(wr_en), .cfg_pad(pad_sel), .cfg_data(wdata),
        .cfg_rdata(rdata), .cfg_rd_jtag_owned(), .route_wr(rt_wr), .route_data(rt_data),
        .input_routing_select(rt_sel), .routed_in(routed), .opt_out(o_out), .opt_drv(o_drv), .pad_in(p_in),
        .pad_out(p_out), .pad_oe_n(p_oe_n), .pad_func_in(f_in), .pad_ana_en(a_en), .pad_medium_drv(med),
        .jtag_tdo(tdo), .jtag_tck(tck), .jtag_tdi(), .jtag_tms(), .jtag_owned(owned), .converter_channel(chan),
        .analog_sensor_inputs(sens), .ext_analog_mux_select(msel), .ext_analog_mux_active(mact),
        .force_alternate_boot(fab), .alternate_boot_select(alt_boot), .boot_mode(bmode), .boot_valid(bval),
        .spi_master(spi_m), .spi_cs(cs), .spi_cs_out(cs_out), .spi_cs_drv(cs_drv), .qspi_master(q_m),
        .serial_flash_mode(flash), .qspi_cs(cs), .qspi_sck_out(1'b1), .qspi_sout(1'b0), .qspi_io_out(4'hA),
        .qspi_io_oe(io_oe), .qspi_sck_in(q_sck), .qspi_sin(q_sin), .qspi_io_in(q_io), .qspi_pad_level(qlev),
        .qspi_opt_out(qout), .qspi_opt_drv(qdrv));
    pfm_pins u_pfm_pins (.pad_out(p_out), .pad_oe_n(p_oe_n), .ext_level(ext), .pad_in(p_in));
    // ==========================================
    // shared helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // pads settle two edges after the write
    task automatic wr(input logic [3:0] p, input logic [4:0] d);
        @(posedge clk_sys);
        pad_sel <= p;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        tick(3);
    endtask
    task automatic restart();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        tick(3);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios
    task automatic t_jtag();
        chk(owned, 4'hF);
        chk({p_oe_n[2], p_out[2]}, 2'h1);
        chk(bmode, pfm_pkg::PFM_BOOT_FLASH);
        @(posedge clk_sys);
        ext <= 16'h0001;
        tdo <= 1'b0;
        tick(3);
        chk({tck, p_out[2]}, 2'h2);
        $display("test jtag done");
    endtask
    task automatic t_alt();
        for (int k = 0; k < 4; k++) begin
            wr(4'h9, 5'(k));
            @(posedge clk_sys);
            o_drv[39:36] <= 4'h1 << k;
            o_out[39:36] <= 4'h1 << k;
            tick(2);
            chk({p_out[9], p_oe_n[9]}, 2'h2);
            @(posedge clk_sys);
            o_drv[39:36] <= ~(4'h1 << k);
            tick(2);
            chk(p_oe_n[9], 1'b1);
        end
        $display("test alt done");
    endtask
    task automatic t_input();
        @(posedge clk_sys);
        ext <= 16'h0040;
        rt_data <= 2'h2;
        rt_wr <= 1'b1;
        @(posedge clk_sys);
        rt_wr <= 1'b0;
        tick(3);
        chk({f_in[6], routed}, 2'h0);
        wr(4'h6, 5'h06);
        chk({f_in[6], routed, rt_sel}, 4'hE);
        @(posedge clk_sys);
        ext <= 16'h0000;
        tick(3);
        chk(routed, 1'b0);
        $display("test input done");
    endtask
    // buffer bit left set: analog must still block digital
    task automatic t_analog();
        @(posedge clk_sys);
        ext <= 16'h0008;
        chan <= 7'h23;
        wr(4'h3, 5'h0C);
        chk({sens, a_en[3], f_in[3], owned}, {16'h0008, 2'h2, 4'h7});
        @(posedge clk_sys);
        chan <= 7'h24;
        tick(2);
        chk(sens, 16'h0000);
        $display("test analog done");
    endtask
    task automatic t_slew();
        wr(4'h7, 5'h10);
        chk({med[7], rdata}, 6'h30);
        wr(4'h7, 5'h00);
        chk(med[7], 1'b0);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            chan <= 7'h40 + 7'(k);
            tick(2);
            chk({mact, msel}, {1'b1, 3'(k)});
        end
        @(posedge clk_sys);
        chan <= 7'h3F;
        tick(2);
        chk({mact, msel}, 4'h7);
        $display("test slew and mux done");
    endtask
    task automatic t_spi();
        @(posedge clk_sys);
        spi_m <= 1'b1;
        q_m <= 1'b1;
        tick(2);
        chk({cs_out, cs_drv, qdrv, qout[2:0]}, {3'h5, 3'h7, 6'h37, 3'h5});
        @(posedge clk_sys);
        spi_m <= 1'b0;
        q_m <= 1'b0;
        qlev <= 6'h28;
        tick(2);
        chk({cs_out, cs_drv, qdrv[5], q_sin, q_sck}, 9'h003);
        @(posedge clk_sys);
        flash <= 1'b1;
        io_oe <= 4'h5;
        tick(2);
        chk({qdrv, q_io, q_sin}, {6'h2B, 4'h1, 1'b0});
        $display("test serial done");
    endtask
    task automatic t_boot();
        fab <= 1'b1;
        restart();
        chk({bval, bmode}, {1'b1, pfm_pkg::PFM_BOOT_CAN});
        alt_boot <= 1'b1;
        restart();
        chk(bmode, pfm_pkg::PFM_BOOT_LIN);
        $display("test boot done");
    endtask
    // ==========================================
    // run control and hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        tick(3);
        t_jtag();
        t_alt();
        t_input();
        t_analog();
        t_slew();
        t_spi();
        t_boot();
        complete_run();
    end
endmodule
bind pfm_top pfm_sva #(.NUM_PADS(NUM_PADS), .ROUTE_N(ROUTE_N), .ROUTE_BASE(ROUTE_BASE)) u_pfm_sva (.*);
`default_nettype wire
